// ### fdhc_drive_model.sv
`timescale 1ns/1ps
// Stand-in for the two drive mechanisms: the optical sensors and the read heads.
module fdhc_drive_model (
  input wire logic clk_i,
  input wire logic [3:0] phase_d0_i,
  input wire logic [3:0] phase_d1_i,
  output logic [1:0] trk0_d_o,
  output logic [1:0] index_d_o,
  output logic [1:0] read_pulse_d_o
);
  // The reference track is seen only while the first coil holds the rotor.
  assign trk0_d_o = {phase_d1_i == 4'h1, phase_d0_i == 4'h1};
  initial begin
    index_d_o = 2'h0;
    read_pulse_d_o = 2'h0;
  end
  task automatic pulses(input int head, input int n);
    repeat (n) begin
      @(posedge clk_i);
      read_pulse_d_o[head] <= 1'h1;
      repeat (2) @(posedge clk_i);
      read_pulse_d_o[head] <= 1'h0;
      @(posedge clk_i);
    end
  endtask
endmodule

// ### fdhc_fifo2.sv
`timescale 1ns/1ps
module fdhc_fifo2 #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH+1)-1:0] level_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [LW-1:0] level_ff;
  logic push;
  logic pop;

  assign in_ready_o = level_ff != LW'(DEPTH);
  assign out_valid_o = level_ff != '0;
  assign out_data_o = mem_ff[rd_ptr_ff];
  assign level_o = level_ff;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      level_ff <= '0;
    end else if (flush_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      level_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= ptr_next(wr_ptr_ff);
      if (pop) rd_ptr_ff <= ptr_next(rd_ptr_ff);
      if (push && !pop) level_ff <= LW'(level_ff + 1'b1);
      else if (pop && !push) level_ff <= LW'(level_ff - 1'b1);
    end
  end
endmodule

// ### fdhc_phase.sv
`timescale 1ns/1ps
module fdhc_phase (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_n_i,
  input wire logic step_i,
  input wire logic out_i,
  output logic [1:0] count_o,
  output logic [3:0] phase_o
);
  import fdhc_pkg::*;
  logic [1:0] count_ff;
  logic [1:0] nxt_count;
  logic [3:0] phase_ff;

  // Two steps move one track, so the count is never tied to a track number.
  always_comb begin
    nxt_count = count_ff;
    if (!clear_n_i) nxt_count = 2'h0;
    else if (step_i && out_i) nxt_count = 2'(count_ff + 2'h1);
    else if (step_i) nxt_count = 2'(count_ff - 2'h1);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_ff <= 2'h0;
      phase_ff <= 4'h1;
    end else begin
      count_ff <= nxt_count;
      phase_ff <= fdhc_phase_drive(nxt_count);
    end
  end

  assign count_o = count_ff;
  assign phase_o = phase_ff;

  step_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (step_i && out_i && clear_n_i) |=> count_o == 2'($past(count_o) + 2'h1))
    else $error("Outward step did not raise the phase count.");
  step_in_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (step_i && !out_i && clear_n_i) |=> count_o == 2'($past(count_o) - 2'h1) && phase_o[count_o])
    else $error("Inward step did not lower the phase count.");
  phase_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (count_o == 2'h3 && step_i && out_i && clear_n_i) |=> count_o == 2'h0 && phase_o == 4'h1)
    else $error("Phase count did not wrap from three to zero.");
endmodule

// ### fdhc_pkg.sv
package fdhc_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STEP = 4'h4;
  localparam logic [3:0] ADDR_WDATA = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'hC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CTRL_W = 7;
  localparam int CB_SEL0 = 0;
  localparam int CB_SEL1 = 1;
  localparam int CB_WGATE = 2;
  localparam int CB_ERASE = 3;
  localparam int CB_OUTER = 4;
  localparam int CB_ENGAGE = 5;
  localparam int CB_DIROUT = 6;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam int ST_TRK0 = 0;
  localparam int ST_IDX = 1;
  localparam int ST_PROT = 2;
  localparam int ST_SUPPLY = 3;
  localparam int ST_PH0 = 4;
  localparam int ST_PH1 = 6;
  localparam int ST_LEVEL = 8;
  localparam int ST_BUSY = 10;
  localparam int ST_RAWCNT = 16;
  localparam int CLK_PERIOD_NS = 25;
  localparam int BIT_TIME_NS = 1000;
  localparam int BIT_CYC = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam logic [5:0] BIT_TICK_LAST = 6'(BIT_CYC - 1);
  localparam logic [4:0] WORD_BIT_LAST = 5'h1F;
  localparam int BUF_DEPTH = 2;
  localparam int BUF_WIDTH = 32;
  typedef enum logic {SER_IDLE, SER_SHIFT} fdhc_ser_e;

  function automatic logic [3:0] fdhc_phase_drive(input logic [1:0] cnt);
    logic [3:0] coils;
    coils = 4'h0;
    coils[cnt] = 1'b1;
    return coils;
  endfunction
endpackage

// ### fdhc_top.sv
`timescale 1ns/1ps
// Functional notes
// - Forward track-zero and index sense of the drive chosen by drive-one select.
// - Write gate starts head writing; erase enable drives the tunnel-erase outputs.
// - Write data goes only to the head whose drive select is set.
// - Write protect or supply low blocks every head write regardless of gate.
// - Outer zone flag selects reduced write current, otherwise full current.
// - Head engage energises drive one solenoid if drive-one select, else drive zero.
// - Initialise low clears drive control state and releases both solenoids.
// - Each drive has its own phase counter; steps reach only selected drives.
// - A step moves outward when direction is set, inward when clear.
// - Outward steps count up, inward count down; count drives four coil outputs.
// - Selected head's digitised read pulses return as active-low raw data.
module fdhc_top (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [fdhc_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [fdhc_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic init_n_i,
  input wire logic protect_inhibit_n_i,
  input wire logic supply_low_n_i,
  input wire logic [1:0] trk0_d_i,
  input wire logic [1:0] index_d_i,
  input wire logic [1:0] read_pulse_d_i,
  output logic track_zero_o,
  output logic index_o,
  output logic raw_data_n_o,
  output logic [1:0] write_en_o,
  output logic [1:0] write_bit_stream_o,
  output logic [1:0] erase_en_o,
  output logic outer_zone_current_o,
  output logic [1:0] solenoid_o,
  output logic [3:0] phase_d0_o,
  output logic [3:0] phase_d1_o
);
  import fdhc_pkg::*;

  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [31:0] nxt_rdata;
  logic [1:0] nxt_rresp;
  logic wr_fire;
  logic wr_hit_data;
  logic [CTRL_W-1:0] ctrl_ff;
  logic step_ff;
  logic [1:0] sel_dk;
  logic wr_ok;
  logic write_act;
  logic trk_sel;
  logic idx_sel;
  logic rd_sel;
  logic track_zero_ff;
  logic index_ff;
  logic raw_n_ff;
  logic rd_prev_ff;
  logic [7:0] raw_cnt_ff;
  logic [1:0] write_en_ff;
  logic [1:0] write_bit_ff;
  logic [1:0] erase_ff;
  logic outer_ff;
  logic [1:0] solenoid_ff;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [31:0] buf_out_data;
  logic [1:0] buf_level;
  fdhc_ser_e ser_state_ff;
  logic [31:0] shreg_ff;
  logic [4:0] bit_cnt_ff;
  logic [5:0] tick_ff;
  logic [1:0] ph_count [2];
  logic [3:0] ph_coils [2];
  logic [31:0] stat_w;

  // Only the second stage of the reset synchroniser is used by the logic.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  function automatic logic reg_known(input logic [ADDR_W-1:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_STEP) || (a == ADDR_WDATA) || (a == ADDR_STAT);
  endfunction

  // A data write waits for buffer room, which is how a stalled head pushes back on software.
  assign wr_hit_data = awaddr_ff == ADDR_WDATA;
  assign wr_fire = !awready_ff && !wready_ff && !bvalid_ff && (!wr_hit_data || buf_in_ready);

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && awready_ff) begin
        awready_ff <= 1'b0;
        awaddr_ff <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_ff) begin
        wready_ff <= 1'b0;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= reg_known(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready_i) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  assign stat_w = {8'h00, raw_cnt_ff, 5'h00, ser_state_ff == SER_SHIFT, buf_level,
    ph_count[1], ph_count[0], !supply_low_n_i, !protect_inhibit_n_i, index_ff, track_zero_ff};

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = RESP_OKAY;
    if (s_axi_araddr_i == ADDR_CTRL) begin
      nxt_rdata = {25'h0000000, ctrl_ff};
    end else if (s_axi_araddr_i == ADDR_STAT) begin
      nxt_rdata = stat_w;
    end else if (!reg_known(s_axi_araddr_i)) begin
      nxt_rresp = RESP_SLVERR;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid_i && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end else if (rvalid_ff && s_axi_rready_i) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o = wready_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_arready_o = arready_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RST;
    end else if (!init_n_i) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_fire && awaddr_ff == ADDR_CTRL && wstrb_ff[0]) begin
      ctrl_ff <= wdata_ff[CTRL_W-1:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      step_ff <= 1'b0;
    end else begin
      step_ff <= wr_fire && awaddr_ff == ADDR_STEP && wstrb_ff[0] && init_n_i;
    end
  end

  assign sel_dk = {ctrl_ff[CB_SEL1], ctrl_ff[CB_SEL0]};
  assign wr_ok = protect_inhibit_n_i && supply_low_n_i && init_n_i;
  assign write_act = ctrl_ff[CB_WGATE] && wr_ok && (sel_dk != 2'h0);
  assign trk_sel = ctrl_ff[CB_SEL1] ? trk0_d_i[1] : trk0_d_i[0];
  assign idx_sel = ctrl_ff[CB_SEL1] ? index_d_i[1] : index_d_i[0];
  assign rd_sel = ctrl_ff[CB_SEL1] ? read_pulse_d_i[1] : read_pulse_d_i[0];

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      track_zero_ff <= 1'b0;
      index_ff <= 1'b0;
      raw_n_ff <= 1'b1;
      rd_prev_ff <= 1'b0;
      raw_cnt_ff <= 8'h00;
    end else begin
      track_zero_ff <= trk_sel;
      index_ff <= idx_sel;
      raw_n_ff <= !rd_sel;
      rd_prev_ff <= rd_sel;
      if (rd_sel && !rd_prev_ff) raw_cnt_ff <= 8'(raw_cnt_ff + 8'h01);
    end
  end

  // A word cut short by a dropped gate is abandoned; the next word starts fresh.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ser_state_ff <= SER_IDLE;
      shreg_ff <= 32'h0000_0000;
      bit_cnt_ff <= 5'h00;
      tick_ff <= 6'h00;
    end else begin
      case (ser_state_ff)
        SER_IDLE: begin
          if (write_act && buf_out_valid) begin
            ser_state_ff <= SER_SHIFT;
            shreg_ff <= buf_out_data;
            bit_cnt_ff <= WORD_BIT_LAST;
            tick_ff <= BIT_TICK_LAST;
          end
        end
        SER_SHIFT: begin
          if (!write_act) begin
            ser_state_ff <= SER_IDLE;
          end else if (tick_ff != 6'h00) begin
            tick_ff <= 6'(tick_ff - 6'h01);
          end else if (bit_cnt_ff == 5'h00) begin
            ser_state_ff <= SER_IDLE;
          end else begin
            shreg_ff <= {shreg_ff[30:0], 1'b0};
            bit_cnt_ff <= 5'(bit_cnt_ff - 5'h01);
            tick_ff <= BIT_TICK_LAST;
          end
        end
        default: ser_state_ff <= SER_IDLE;
      endcase
    end
  end

  assign buf_out_ready = ser_state_ff == SER_IDLE && write_act;

  fdhc_fifo2 #(
    .WIDTH(BUF_WIDTH),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .flush_i(!init_n_i),
    .in_valid_i(wr_fire && wr_hit_data),
    .in_ready_o(buf_in_ready),
    .in_data_i(wdata_ff),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_out_ready),
    .out_data_o(buf_out_data),
    .level_o(buf_level)
  );

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      write_en_ff <= 2'h0;
      write_bit_ff <= 2'h0;
      erase_ff <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        write_en_ff[i] <= ctrl_ff[CB_WGATE] && sel_dk[i] && wr_ok;
        write_bit_ff[i] <= write_act && sel_dk[i] && ser_state_ff == SER_SHIFT && shreg_ff[31];
        erase_ff[i] <= ctrl_ff[CB_ERASE] && sel_dk[i] && wr_ok;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      outer_ff <= 1'b0;
    end else begin
      outer_ff <= ctrl_ff[CB_OUTER];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      solenoid_ff <= 2'h0;
    end else if (!init_n_i) begin
      solenoid_ff <= 2'h0;
    end else begin
      solenoid_ff[1] <= ctrl_ff[CB_ENGAGE] && ctrl_ff[CB_SEL1];
      solenoid_ff[0] <= ctrl_ff[CB_ENGAGE] && !ctrl_ff[CB_SEL1];
    end
  end

  generate
    for (genvar d = 0; d < 2; d++) begin : g_drive
      fdhc_phase u_phase (
        .clk_i(mclk_i),
        .rst_n_i(rst_n),
        .clear_n_i(init_n_i),
        .step_i(step_ff && sel_dk[d]),
        .out_i(ctrl_ff[CB_DIROUT]),
        .count_o(ph_count[d]),
        .phase_o(ph_coils[d])
      );
    end
  endgenerate

  assign track_zero_o = track_zero_ff;
  assign index_o = index_ff;
  assign raw_data_n_o = raw_n_ff;
  assign write_en_o = write_en_ff;
  assign write_bit_stream_o = write_bit_ff;
  assign erase_en_o = erase_ff;
  assign outer_zone_current_o = outer_ff;
  assign solenoid_o = solenoid_ff;
  assign phase_d0_o = ph_coils[0];
  assign phase_d1_o = ph_coils[1];

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n);

  sense_mux_a: assert property (rst_n |=> track_zero_o == $past(trk_sel) && index_o == $past(idx_sel))
    else $error("Sense outputs do not follow the selected drive.");
  write_gate_a: assert property ((ctrl_ff[CB_WGATE] && sel_dk[0] && wr_ok) |=> write_en_o[0])
    else $error("Write gate did not enable drive zero writing.");
  steer_a: assert property (!sel_dk[1] |=> !write_en_o[1] && !write_bit_stream_o[1])
    else $error("Write reached an unselected head.");
  write_inhibit_a: assert property (!(protect_inhibit_n_i && supply_low_n_i) |=>
    write_en_o == 2'h0 && write_bit_stream_o == 2'h0 && erase_en_o == 2'h0)
    else $error("Head writing while protect or supply low.");
  write_current_a: assert property (ctrl_ff[CB_OUTER] |=> outer_zone_current_o)
    else $error("Reduced write current not selected.");
  solenoid_sel_a: assert property ((ctrl_ff[CB_ENGAGE] && ctrl_ff[CB_SEL1] && init_n_i) |=>
    solenoid_o == 2'h2)
    else $error("Wrong head load solenoid energised.");
  init_unload_a: assert property (!init_n_i |=> solenoid_o == 2'h0 && ctrl_ff == CTRL_RST ##1
    write_en_o == 2'h0)
    else $error("Initialise did not unload the head.");
  step_gate_a: assert property ((step_ff && !sel_dk[0]) |=> $stable(phase_d0_o))
    else $error("Step reached an unselected drive.");
  step_move_a: assert property ((step_ff && sel_dk[1] && init_n_i) |=> !$stable(phase_d1_o))
    else $error("Step did not move the selected drive.");
  raw_data_a: assert property (1'b1 |=> raw_data_n_o == !$past(rd_sel))
    else $error("Raw data does not follow the selected head.");

  step_seen_c: cover property (step_ff && sel_dk[0] ##1 step_ff && sel_dk[0]);
  buf_full_c: cover property (buf_level == 2'h2 && !buf_in_ready);
  bit_out_c: cover property (write_bit_stream_o[0] ##[1:80] !write_bit_stream_o[0]);
  head_load_c: cover property (solenoid_o == 2'h1);
endmodule

// ### floppy_drive_head_control_tb_top.sv
`timescale 1ns/1ps
module floppy_drive_head_control_tb_top;
  import fdhc_pkg::*;
  logic mclk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic [ADDR_W-1:0] awaddr = 4'h0;
  logic [ADDR_W-1:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic init_n = 1'h1, prot_n = 1'h1, sup_n = 1'h1, probe = 1'h0, clr = 1'h0;
  logic [1:0] psel = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, trk0, idx, raw_n, outer;
  logic [1:0] bresp, rresp, we, wbs, er, sol, trk0_d, index_d, rp_d;
  logic [31:0] rdata, hc0 = 32'h0, hc1 = 32'h0;
  logic [3:0] ph0, ph1;
  logic [15:0] pins, lf = 16'h261A;
  logic [65:0] re;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  logic [31:0] pq[$];
  int err_total = 0;
  int checks = 0;
  always #12.5 mclk_i = ~mclk_i;
  assign pins = {raw_n, sol, we, er, outer, ph0, ph1};
  fdhc_top i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .init_n_i(init_n),
    .protect_inhibit_n_i(prot_n), .supply_low_n_i(sup_n), .trk0_d_i(trk0_d), .index_d_i(index_d),
    .read_pulse_d_i(rp_d), .track_zero_o(trk0), .index_o(idx), .raw_data_n_o(raw_n), .write_en_o(we),
    .write_bit_stream_o(wbs), .erase_en_o(er), .outer_zone_current_o(outer), .solenoid_o(sol),
    .phase_d0_o(ph0), .phase_d1_o(ph1));
  fdhc_drive_model m (.clk_i(mclk_i), .phase_d0_i(ph0), .phase_d1_i(ph1), .trk0_d_o(trk0_d),
    .index_d_o(index_d), .read_pulse_d_o(rp_d));
  task automatic complete_run(input logic to);
    if (to) err_total++;
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  function automatic logic [15:0] pv(input logic [6:0] v, input logic ok, input int c0, input int c1);
    logic [1:0] s;
    s = v[5] ? (v[1] ? 2'h2 : 2'h1) : 2'h0;
    return {1'h1, s, (v[2] && ok) ? v[1:0] : 2'h0, (v[3] && ok) ? v[1:0] : 2'h0, v[4],
            4'h1 << (c0 % 4), 4'h1 << (c1 % 4)};
  endfunction
  always @(posedge mclk_i) begin
    if (bready && bvalid === 1'h1) chk("bresp", 32'(bq.pop_front()), 32'(bresp));
    if (rready && rvalid === 1'h1) begin
      re = rq.pop_front();
      chk("rdata", re[31:0], rdata & re[63:32]);
      chk("rresp", 32'(re[65:64]), 32'(rresp));
    end
    if (probe) chk("pins", pq.pop_front(), psel == 2'h0 ? 32'(pins) : (psel == 2'h1 ? hc0 :
      (psel == 2'h2 ? hc1 : 32'({idx, trk0}))));
    hc0 <= clr ? 32'h0 : hc0 + 32'(wbs[0]);
    hc1 <= clr ? 32'h0 : hc1 + 32'(wbs[1]);
  end
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    logic [2:0] p;
    int n;
    p = 3'h7;
    bq.push_back(r);
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 2000 && p != 3'h0; n++) begin
      @(posedge mclk_i);
      if (p[0] && awready === 1'h1) begin
        awvalid <= 1'h0;
        p[0] = 1'h0;
      end
      if (p[1] && wready === 1'h1) begin
        wvalid <= 1'h0;
        p[1] = 1'h0;
      end
      if (p[2] && !p[1] && !p[0] && bvalid === 1'h1) begin
        bready <= 1'h0;
        p[2] = 1'h0;
      end
    end
    if (p != 3'h0) complete_run(1'h1);
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] mk, input logic [31:0] e,
                     input logic [1:0] r, output logic [31:0] d);
    int n;
    rq.push_back({r, mk, e & mk});
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 2000; n++) begin
      @(posedge mclk_i);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) begin
        d = rdata;
        rready <= 1'h0;
        break;
      end
    end
    if (n == 2000) complete_run(1'h1);
  endtask
  task automatic pin(input logic [1:0] s, input logic [31:0] e);
    repeat (3) @(posedge mclk_i);
    pq.push_back(e);
    psel <= s;
    probe <= 1'h1;
    @(posedge mclk_i);
    probe <= 1'h0;
  endtask
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  initial begin
    logic [31:0] d, w[3];
    logic [6:0] tv[4];
    int c0, c1, n, tot;
    tv = '{7'h2D, 7'h3E, 7'h22, 7'h20};
    repeat (8) @(posedge mclk_i);
    rstn_i <= 1'h1;
    repeat (3) @(posedge mclk_i);
    axr(ADDR_CTRL, 32'hFFFF_FFFF, 32'h0, RESP_OKAY, d);
    axr(ADDR_STAT, 32'h0000_03FF, 32'h1, RESP_OKAY, d);
    pin(2'h0, 32'(pv(7'h00, 1'h1, 0, 0)));
    axw(4'h2, 32'h7F, RESP_SLVERR);
    axr(4'h7, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR, d);
    axr(ADDR_CTRL, 32'hFFFF_FFFF, 32'h0, RESP_OKAY, d);
    fork
      m.pulses(0, 3);
      m.pulses(1, 5);
    join
    axr(ADDR_STAT, 32'h00FF_0000, 32'h0003_0000, RESP_OKAY, d);
    axw(ADDR_CTRL, 32'h02, RESP_OKAY);
    fork
      m.pulses(0, 2);
      m.pulses(1, 4);
    join
    axr(ADDR_STAT, 32'h00FF_0000, 32'h0007_0000, RESP_OKAY, d);
    // Step counts stay even so each move is a whole number of tracks.
    lf = nxt(lf);
    c0 = 2 * (int'(lf[1:0]) + 1);
    c1 = 4 - (2 * (int'(lf[3:2]) + 1)) % 4;
    axw(ADDR_CTRL, 32'h41, RESP_OKAY);
    repeat (c0) axw(ADDR_STEP, 32'h1, RESP_OKAY);
    axw(ADDR_CTRL, 32'h02, RESP_OKAY);
    repeat (2 * (int'(lf[3:2]) + 1)) axw(ADDR_STEP, 32'h1, RESP_OKAY);
    axw(ADDR_CTRL, 32'h43, RESP_OKAY);
    repeat (2) axw(ADDR_STEP, 32'h1, RESP_OKAY);
    c0 = (c0 + 2) % 4;
    c1 = (c1 + 2) % 4;
    axr(ADDR_STAT, 32'hF0, 32'((c1 << 6) | (c0 << 4)), RESP_OKAY, d);
    pin(2'h0, 32'(pv(7'h43, 1'h1, c0, c1)));
    m.index_d_o <= 2'h1;
    axr(ADDR_STAT, 32'h3, 32'(c1 == 0), RESP_OKAY, d);
    axw(ADDR_CTRL, 32'h01, RESP_OKAY);
    axr(ADDR_STAT, 32'h3, 32'h2 | 32'(c0 == 0), RESP_OKAY, d);
    pin(2'h3, 32'h2 | 32'(c0 == 0));
    foreach (tv[i]) begin
      axw(ADDR_CTRL, 32'(tv[i]), RESP_OKAY);
      pin(2'h0, 32'(pv(tv[i], 1'h1, c0, c1)));
    end
    axw(ADDR_CTRL, 32'h0D, RESP_OKAY);
    for (n = 0; n < 2; n++) begin
      prot_n <= (n != 0);
      sup_n <= (n == 0);
      pin(2'h0, 32'(pv(7'h0D, 1'h0, c0, c1)));
      axr(ADDR_STAT, 32'hC, 32'h4 << n, RESP_OKAY, d);
    end
    sup_n <= 1'h1;
    prot_n <= 1'h0;
    axw(ADDR_CTRL, 32'h05, RESP_OKAY);
    clr <= 1'h1;
    for (n = 0; n < 3; n++) begin
      lf = nxt(lf);
      w[n][31:16] = lf;
      lf = nxt(lf);
      w[n][15:0] = lf;
    end
    @(posedge mclk_i);
    clr <= 1'h0;
    axw(ADDR_WDATA, w[0], RESP_OKAY);
    axw(ADDR_WDATA, w[1], RESP_OKAY);
    fork
      axw(ADDR_WDATA, w[2], RESP_OKAY);
      begin
        repeat (60) @(posedge mclk_i);
        axr(ADDR_STAT, 32'h300, 32'h200, RESP_OKAY, d);
        prot_n <= 1'h1;
      end
    join
    d = 32'hFFFF_FFFF;
    for (n = 0; n < 100 && d[10:8] != 3'h0; n++) begin
      repeat (100) @(posedge mclk_i);
      axr(ADDR_STAT, 32'h0, 32'h0, RESP_OKAY, d);
    end
    if (d[10:8] != 3'h0) complete_run(1'h1);
    tot = BIT_CYC * ($countones(w[0]) + $countones(w[1]) + $countones(w[2]));
    pin(2'h1, 32'(tot));
    pin(2'h2, 32'h0);
    axw(ADDR_CTRL, 32'h27, RESP_OKAY);
    init_n <= 1'h0;
    axw(ADDR_STEP, 32'h1, RESP_OKAY);
    init_n <= 1'h1;
    axr(ADDR_CTRL, 32'hFFFF_FFFF, 32'h0, RESP_OKAY, d);
    axr(ADDR_STAT, 32'hF0, 32'h0, RESP_OKAY, d);
    pin(2'h0, 32'(pv(7'h00, 1'h1, 0, 0)));
    complete_run(1'h0);
  end
endmodule
